// >>> design/rpc_reset_pin_control.sv
// Reset pin controller: filters the active-high reset pin, runs the watchdog pulse
// Operation
// - Enter reset after two high machine cycles
// - No instruction fetch while reset held
// - Peripherals stopped, I/O drivers tristated in reset
// - Watchdog expiry turns reset pin to output
// - Watchdog drives bounded high pulse, then releases
// - Execution restarts at fixed reset vector
// - Special function registers default on leaving reset
// - I/O control registers held default during reset
// - No data memory access during reset
`include "rpc_cfg.svh"
module rpc_reset_pin_control
    import rpc_pkg::*;
#(
    parameter int WDT_TIMEOUT_CLKS = `RPC_WDT_TIMEOUT_CLKS // Shortenable for simulation
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    input wire logic wdt_enable,
    input wire logic wdt_kick,
    output logic core_halt,
    output logic core_pc_load,
    output rpc_addr_t core_pc_value,
    output logic periph_stop,
    output logic gpio_tristate,
    output logic special_function_registers_reset,
    output logic io_ctrl_reset,
    output logic dmem_access_block
);
    // Timing in clocks, worked out from the machine cycle length
    // A machine cycle is rounded up to whole clocks so the filter never runs short
    localparam int MC_CLKS = `RPC_MC_CLKS;
    localparam int HOLD_CLKS = MC_CLKS * `RPC_HOLD_MCS;
    localparam int PULSE_CLKS = MC_CLKS * `RPC_WDT_PULSE_MCS;

    // Filter, pulse and watchdog state
    logic pin_sync;               // Synchronised pin level
    rpc_state_e state_reg;        // Controller state
    rpc_state_e state_next;       // Next controller state
    logic [15:0] hold_cnt_reg;    // Clocks the pin has stayed high
    logic [15:0] hold_cnt_next;   // Next hold count
    logic [15:0] pulse_cnt_reg;   // Clocks left in the watchdog pulse
    logic [15:0] pulse_cnt_next;  // Next pulse count
    logic [31:0] wdt_cnt_reg;     // Watchdog count
    logic [31:0] wdt_cnt_next;    // Next watchdog count
    logic in_reset_reg;           // Registered reset condition

    // Pin is asynchronous to ref_clk
    // Two flops keep a slow edge on the pin from going metastable
    rpc_sync u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in(rst_pin_in),
        .sync_out(pin_sync)
    );

    // Decode of filter, watchdog and state conditions
    // The filter is judged on the synchronised pin only, never the raw pad
    wire hold_done = (hold_cnt_reg >= 16'(HOLD_CLKS - 1));
    wire pin_qualified = pin_sync && hold_done;
    // Expiry is ignored while held, so a held chip never pulses the pin
    wire wdt_expire = wdt_enable && !in_reset_reg &&
                      (wdt_cnt_reg >= 32'(WDT_TIMEOUT_CLKS - 1));
    // Pulse ends as the count reaches its last clock
    wire pulse_done = (pulse_cnt_reg == 16'h0001);
    // Reset condition and its falling edge, one clock ahead of the output flops
    wire in_reset_next = (state_next != RPC_RUN);
    wire leaving_reset = in_reset_reg && !in_reset_next;

    // Hold count: a single low sample restarts the filter so glitches never reset
    // Count saturates so a long hold never wraps back to zero
    assign hold_cnt_next = !pin_sync ? 16'h0000 :
                           hold_done ? hold_cnt_reg : hold_cnt_reg + 16'h0001;
    // Watchdog counts only while running; kick or reset restarts it
    // A kick held high keeps the count at zero
    assign wdt_cnt_next = (in_reset_reg || wdt_kick || !wdt_enable) ? 32'h0000_0000 :
                          wdt_cnt_reg + 32'h0000_0001;
    // Pulse count loads on expiry and runs down while driving
    // Counter is idle at zero outside the pulse
    assign pulse_cnt_next = wdt_expire ? 16'(PULSE_CLKS) :
                            (state_reg == RPC_WDOG && pulse_cnt_reg != 16'h0000) ?
                            pulse_cnt_reg - 16'h0001 : 16'h0000;

    // State transitions
    always_comb begin
        // Default: stay in the present state
        state_next = state_reg;
        case (state_reg)
            RPC_RUN: begin
                // Watchdog first: its pulse wins over a pin that rises at once
                if (wdt_expire) begin
                    state_next = RPC_WDOG;
                end else if (pin_qualified) begin
                    state_next = RPC_HELD;
                end
            end
            RPC_HELD: begin
                // Stay while the supervisor keeps the pin high
                if (!pin_sync) begin
                    state_next = RPC_RUN;
                end
            end
            RPC_WDOG: begin
                // Our own pulse reads back high; hand over to pin hold afterwards
                if (pulse_done) begin
                    state_next = RPC_HELD;
                end
            end
            default: begin
                // Unused code: fall back to running
                state_next = RPC_RUN;
            end
        endcase
    end

    // Next pin drive: only the watchdog pulse ever turns the pin around
    wire pin_drive_next = (state_next == RPC_WDOG);
    // One hold-off condition feeds every reset output so they move as one
    wire hold_off_next = in_reset_next;

    // Controller state
    // State moves on every clock; there is no clock enable
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= RPC_RUN; // Chip reset leaves the core free to run
        end else begin
            state_reg <= state_next;
        end
    end

    // Pin filter count
    // Restarts on any low sample of the synchronised pin
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hold_cnt_reg <= 16'h0000; // Filter starts empty
        end else begin
            hold_cnt_reg <= hold_cnt_next;
        end
    end

    // Watchdog pulse count
    // Loaded on expiry, runs down to zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pulse_cnt_reg <= 16'h0000; // No pulse pending
        end else begin
            pulse_cnt_reg <= pulse_cnt_next;
        end
    end

    // Watchdog timeout count
    // Kept at 32 bits so a long timeout never wraps before it expires
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wdt_cnt_reg <= 32'h0000_0000; // Timeout starts afresh
        end else begin
            wdt_cnt_reg <= wdt_cnt_next;
        end
    end

    // Reset condition, one clock behind, so its exit edge can be found
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            in_reset_reg <= 1'b0; // Not held after a chip reset
        end else begin
            in_reset_reg <= in_reset_next;
        end
    end

    // Pin drive: value and enable move together, so the pin is never
    // driven low against the supervisor
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rst_pin_out <= 1'b0;
            rst_pin_oe <= 1'b0; // Pin released while the chip resets
        end else begin
            rst_pin_out <= pin_drive_next;
            rst_pin_oe <= pin_drive_next;
        end
    end

    // Core controls: halted while held, then one vector load on exit
    // The load pulse lines up with the fall of the halt
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            core_halt <= 1'b0;
            core_pc_load <= 1'b0;
            core_pc_value <= `RPC_RESET_VECTOR;
        end else begin
            core_halt <= hold_off_next;
            core_pc_load <= leaving_reset;
            core_pc_value <= `RPC_RESET_VECTOR;
        end
    end

    // Peripherals and I/O drivers stay off for the whole reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            periph_stop <= 1'b0;
            gpio_tristate <= 1'b0;
            io_ctrl_reset <= 1'b0;
        end else begin
            periph_stop <= hold_off_next;
            gpio_tristate <= hold_off_next;
            io_ctrl_reset <= hold_off_next;
        end
    end

    // Register defaults and the data memory guard
    // Memory contents are left alone; only the access path is shut
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            special_function_registers_reset <= 1'b0;
            dmem_access_block <= 1'b0;
        end else begin
            special_function_registers_reset <= hold_off_next;
            dmem_access_block <= hold_off_next;
        end
    end
endmodule : rpc_reset_pin_control

// >>> design/rpc_cfg.svh
// Timing counts and vectors for the reset pin controller
`ifndef RPC_CFG_SVH
`define RPC_CFG_SVH
`define RPC_CLK_PERIOD_NS 10
`define RPC_MACHINE_CYCLE_NS 120
`define RPC_MC_CLKS ((`RPC_MACHINE_CYCLE_NS + `RPC_CLK_PERIOD_NS - 1) / `RPC_CLK_PERIOD_NS)
`define RPC_HOLD_MCS 2
`define RPC_WDT_PULSE_MCS 96
`define RPC_WDT_TIMEOUT_CLKS 16384
`define RPC_RESET_VECTOR 16'h0000
`endif

// >>> design/rpc_pkg.sv
// Types shared by the reset pin controller
package rpc_pkg;
    typedef enum logic [1:0] {
        RPC_RUN = 2'b00,    // Normal execution
        RPC_HELD = 2'b01,   // Reset held by the pin
        RPC_WDOG = 2'b10    // Driving the watchdog pulse
    } rpc_state_e;
    typedef logic [15:0] rpc_addr_t;
endpackage : rpc_pkg

// >>> design/rpc_sync.sv
// Two-flop synchroniser for the reset pin input
module rpc_sync (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg; // First stage, read only by the second
    // Both stages clear to low so the chip leaves reset with the pin idle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : rpc_sync

// >>> verification/rpc_chk_assertions.sv
// Port checker for the reset pin controller
`include "rpc_cfg.svh"
module rpc_chk
    import rpc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic rst_pin_in,
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe,
    input wire logic core_halt,
    input wire logic core_pc_load,
    input wire rpc_addr_t core_pc_value,
    input wire logic periph_stop,
    input wire logic gpio_tristate,
    input wire logic special_function_registers_reset,
    input wire logic io_ctrl_reset,
    input wire logic dmem_access_block
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PULSE_CLKS = `RPC_MC_CLKS * `RPC_WDT_PULSE_MCS; // Pulse length in clocks
    logic [15:0] oe_len; // Clocks the pin drive has stood high so far
    // Count the drive run, since the pulse is far too long for a delay range
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            oe_len <= 16'h0000;
        end else begin
            oe_len <= rst_pin_oe ? oe_len + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Pulse steps: drive with halt, stay up, then let go after the full count
    sequence s_drive; rst_pin_oe && rst_pin_out && core_halt; endsequence
    sequence s_release; rst_pin_oe [*8]; endsequence
    property p_wdog; $rose(rst_pin_oe) |-> s_drive; endproperty
    a_wdog: assert property (p_wdog) else $error("pulse start wrong");
    property p_pulse; $rose(rst_pin_oe) |-> s_release; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse dropped early");
    property p_width; $fell(rst_pin_oe) |-> oe_len == 16'(PULSE_CLKS); endproperty
    a_width: assert property (p_width) else $error("pulse length wrong");
    property p_bound; rst_pin_oe |-> oe_len < 16'(PULSE_CLKS); endproperty
    a_bound: assert property (p_bound) else $error("pulse too long");
    // A pin halt needs the pin high well before it
    property p_filt;
        $rose(core_halt) && !rst_pin_oe |-> $past(rst_pin_in, 3) && $past(rst_pin_in, 20);
    endproperty
    a_filt: assert property (p_filt) else $error("halt without long pin");
    property p_nofetch; core_halt |-> !core_pc_load; endproperty
    a_nofetch: assert property (p_nofetch) else $error("fetch in reset");
    property p_stop; core_halt |-> periph_stop && gpio_tristate; endproperty
    a_stop: assert property (p_stop) else $error("periph or io live");
    property p_regs; core_halt |-> special_function_registers_reset && io_ctrl_reset; endproperty
    a_regs: assert property (p_regs) else $error("registers not held");
    property p_mem; core_halt |-> dmem_access_block; endproperty
    a_mem: assert property (p_mem) else $error("memory open in reset");
    property p_vec;
        $fell(core_halt) |-> ##[0:1] core_pc_load && core_pc_value == 16'h0000;
    endproperty
    a_vec: assert property (p_vec) else $error("no restart at vector");
endmodule : rpc_chk

// >>> verification/rpc_supervisor.sv
// Model of the external supply supervisor on the reset pin
module rpc_supervisor (
    input wire logic ref_clk,
    input wire logic supply_low,
    output logic pin_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pin high while supply is low; released pin falls to the pull-down level
    always_ff @(posedge ref_clk) begin
        pin_drive <= supply_low;
    end
endmodule : rpc_supervisor

// >>> verification/rpc_reset_pin_control_bench.sv
// Self-checking bench for the reset pin controller
`include "rpc_cfg.svh"
module rpc_reset_pin_control_bench import rpc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, reset = 1, supply_low = 0, wdt_enable = 0, wdt_kick = 0;
    logic sup_drive, rst_pin_out, rst_pin_oe, core_halt, core_pc_load, periph_stop, gpio_tristate;
    logic sfr_rst, io_rst, dmem_blk, seen;
    rpc_addr_t core_pc_value;
    int fails = 0, compares = 0, seed = 32'he53b, n, r;
    wire rst_pin = sup_drive | (rst_pin_oe & rst_pin_out); // Supervisor ORed with own drive
    wire [4:0] held_bits = {periph_stop, gpio_tristate, sfr_rst, io_rst, dmem_blk}; // Hold-offs
    always #5 ref_clk = ~ref_clk;
    rpc_supervisor i_sup (.ref_clk(ref_clk), .supply_low(supply_low), .pin_drive(sup_drive));
    rpc_reset_pin_control #(.WDT_TIMEOUT_CLKS(64)) i_dut (.ref_clk(ref_clk), .reset(reset),
        .rst_pin_in(rst_pin), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
        .wdt_enable(wdt_enable), .wdt_kick(wdt_kick), .core_halt(core_halt),
        .core_pc_load(core_pc_load), .core_pc_value(core_pc_value), .periph_stop(periph_stop),
        .gpio_tristate(gpio_tristate), .special_function_registers_reset(sfr_rst),
        .io_ctrl_reset(io_rst), .dmem_access_block(dmem_blk));
    task automatic chk(string name, logic [15:0] got, logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic results;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    // Only pins held for the two machine cycle filter halt the core
    function automatic logic exp_halt(int len);
        return len >= `RPC_MC_CLKS * `RPC_HOLD_MCS;
    endfunction : exp_halt
    // Hold the supply low for len cycles, then watch the halt and the restart
    task automatic pin_pulse(int len);
        seen = 0;
        n = 0;
        @(posedge ref_clk) supply_low <= 1;
        for (int k = 1; k <= len + 16; k++) begin
            @(posedge ref_clk);
            if (k == len) supply_low <= 0;
            seen |= core_halt;
            n += core_pc_load;
            if (core_halt === 1) chk("held", held_bits, 5'h1f);
            if (core_pc_load === 1) chk("vector", core_pc_value, 16'h0000);
        end
        chk("halt", seen, exp_halt(len));
        chk("loads", n[15:0], {15'h0, exp_halt(len)});
        chk("run", core_halt, 0);
    endtask : pin_pulse
    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 0;
        @(posedge ref_clk) chk("idle", core_halt, 0);
        pin_pulse(20);
        pin_pulse(30);
        pin_pulse(23);
        pin_pulse(24);
        repeat (8) begin
            r = $unsigned($random(seed)) % 80;
            pin_pulse(r < 40 ? 1 + r % 20 : r - 10);
        end
        // Random kicks keep the watchdog quiet, then it is starved
        wdt_enable <= 1;
        seen = 0;
        repeat (300) @(posedge ref_clk) begin
            wdt_kick <= ($random(seed) & 3) == 0;
            seen |= rst_pin_oe;
        end
        chk("kicked", seen, 0);
        wdt_kick <= 0;
        n = 0;
        while (rst_pin_oe !== 1 && n < 100) @(posedge ref_clk) n++;
        chk("drive", {rst_pin_oe, rst_pin_out, core_halt}, 3'h7);
        n = 0;
        while (rst_pin_oe === 1 && n < 1300) @(posedge ref_clk) n++;
        chk("width", n[15:0], 16'h0480);
        wdt_enable <= 0;
        repeat (12) @(posedge ref_clk);
        chk("rerun", core_halt, 0);
        results;
    end
    initial begin
        #100us;
        fails++;
        results;
    end
endmodule : rpc_reset_pin_control_bench
bind rpc_reset_pin_control rpc_chk i_chk (.*);
